// *** hdl/record_mem.sv ***
/*
 Precise records buffer: 256 words of 32 bits, one write port,
 one read port with registered read data.
 Assumes a single clock shared with the sampling core.
*/
`timescale 1ns/1ps
`default_nettype none
module record_mem (
    input  wire logic        clk_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  waddr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [7:0]  raddr_i,
    output logic      [31:0] rdata_o
);
    logic [31:0] mem_reg [0:255];

    // Write port and registered read port
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[raddr_i];
    end
endmodule
`default_nettype wire

// *** hdl/sampling_core.sv ***
/*
 Retirement tagging feeding counter four, precise records kept
 in a local buffer.
 Assumes a Wishbone master and core inputs on clk_i.
*/
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: Each detector sees only its own tags.
// R2: Software enables one mechanism when precise.
// R3: Never tag io, uncached, locked, return, far.
// R4: Front-end counts need a path mask bit.
// R5: Upstream: tag enable bit 4, value 8:5.
// R6: Downstream adds one when selected tag set.
// R7: Downstream tag fields do not affect counting.
// R8: Software matches tag value to downstream mask.
// R9: Combinations of tag bits count together.
// R10: Replay needs matrix, event type, bit 24.
// R11: Replay tags work with bits 24,25 clear.
// R12: Overflow writes state record, reloads counter.
// R13: Interrupt near full, no circular wrap.
// R14: Precise only tagged events, counter four.
// R15: Identification bit 21 reports store present.
// R16: Absent flag reads clear.
// R17: Bit 24 turns precise sampling on, off.
// R18: Software sets buffer fields before enabling.
// R19: One shared interrupt output for all sampling.
// R20: Disabled on entering and during management mode.
// R21: Machine check disables; reset, init clear.
// R22: Works unchanged in real address mode.
// R23: Advance index per record, compare threshold.
module sampling_core (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [11:0]               wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire sampling_pkg::uop_s        retire_i,
    input  wire sampling_pkg::arch_state_s arch_i,
    input  wire logic                      smm_i,
    input  wire logic                      machine_check_i,
    input  wire logic                      init_i,
    output logic                           irq_o
);
    import sampling_pkg::*;

    // Byte-lane merge of a bus write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Word k of a record: gpr 0..7, flags, ip
    function automatic logic [31:0] rec_word(input arch_state_s s,
                                             input logic [3:0]  k);
        logic [31:0] w;
        w = s.ip;
        if (k < 4'h8)
        begin
            w = s.gpr[k[2:0]];
        end
        else if (k == 4'h8)
        begin
            w = s.flags;
        end
        return w;
    endfunction

    logic [31:0] pse_reg, pse_next;
    logic [31:0] matrix_reg, misc_reg, up_reg, dn_reg, fe_reg;
    logic [31:0] cfg_reg, count_reg, count_next;
    logic [31:0] base_reg, index_reg, index_next;
    logic [31:0] absmax_reg, thresh_reg, reload_reg;
    logic [2:0]  sticky_reg, sticky_next;
    logic        smm_d_reg, req_reg, ack_reg;
    logic [31:0] dat_reg, reg_rdata, mem_rdata;
    logic [3:0]  word_reg;
    arch_state_s snap_reg;
    wr_state_e   state_reg;

    // Bus decode: request seen, write at the ack edge
    wire clr      = rst_i | init_i;                    // [R21]
    wire bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg & ~req_reg;
    wire wr_en    = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i;
    wire in_mem   = (wb_adr_i[11:10] == MEM_WINDOW);
    wire wr_pse   = wr_en && (wb_adr_i == OFF_PSE);
    wire wr_count = wr_en && (wb_adr_i == OFF_COUNT);
    wire wr_index = wr_en && (wb_adr_i == OFF_INDEX);
    wire wr_stat  = wr_en && (wb_adr_i == OFF_STATUS);
    wire [31:0] wmerge_pse = merge(pse_reg, wb_dat_i, wb_sel_i);

    // Mode events
    wire smm_entry = smm_i & ~smm_d_reg;
    wire active    = cfg_reg[CFG_EN_BIT] & ~smm_i;     // [R20] [R22]
    wire precise   = pse_reg[PSE_EN_BIT];              // [R17]

    // Tagging, each mechanism on its own tag
    wire untag = retire_i.io | retire_i.uncached | retire_i.locked
               | retire_i.is_return | retire_i.far_xfer;  // [R3]
    wire ok_uop = retire_i.valid & ~untag;
    wire fe_tag = ok_uop & |(retire_i.fe_hits & fe_reg[3:0]);
    wire up_hit = ok_uop & up_reg[TAG_EN_BIT]
                & |(retire_i.exec_hits & up_reg[3:0]);       // [R5]
    wire [3:0] exec_tag = up_hit ? up_reg[TAG_VAL_LSB +: 4]
                                 : 4'h0;                     // [R5]
    wire replay_on = precise | ~pse_reg[PSE_AUX_BIT];  // [R10] [R11]
    wire rp_tag = ok_uop & replay_on
                & |(retire_i.replay_hits & matrix_reg[3:0]
                    & pse_reg[3:0]);                         // [R10]

    // Downstream selection by path mask; tag fields ignored
    wire [3:0] path_mask = retire_i.correct_path
                         ? dn_reg[CP_MASK_LSB +: 4]
                         : dn_reg[WP_MASK_LSB +: 4];        // [R7]
    wire [2:0] dn_evt = dn_reg[DN_EVT_LSB +: 3];
    wire fe_cnt   = fe_tag & path_mask[0];                   // [R4]
    wire exec_cnt = |(exec_tag & path_mask);           // [R6] [R9]
    wire rp_cnt   = rp_tag & path_mask[0];
    wire ret_cnt  = retire_i.valid & path_mask[0];
    wire hit = (dn_evt == EVT_FRONT)   ? fe_cnt :
               (dn_evt == EVT_EXEC)    ? exec_cnt :
               (dn_evt == EVT_REPLAY)  ? rp_cnt :
               (dn_evt == EVT_RETIRED) ? ret_cnt : 1'b0;     // [R1]
    wire precise_evt = (dn_evt == EVT_FRONT) | (dn_evt == EVT_EXEC)
                     | (dn_evt == EVT_REPLAY);               // [R14]

    // Counter four increment and overflow
    wire inc = active & hit;
    wire ovf = inc & (count_reg == 32'hffff_ffff);

    // Record start, room check without wrap
    wire [32:0] idx_adv = {1'b0, index_reg} + {29'h0, RECORD_WORDS};
    wire room  = idx_adv <= {1'b0, absmax_reg};              // [R13]
    wire start = ovf & precise & precise_evt
               & (state_reg == ST_IDLE);                     // [R14]
    wire busy  = (state_reg == ST_WRITE);
    wire advance = busy & (word_reg == LAST_WORD);
    wire mem_we  = busy & ~smm_i;
    wire [7:0] mem_waddr = index_reg[7:0] + {4'h0, word_reg};
    wire [31:0] mem_wdata = rec_word(snap_reg, word_reg);    // [R12]

    // Sticky events: set wins over write-one-to-clear
    wire [2:0] st_set;
    assign st_set[ST_THRESH_BIT] = advance
                                 && (idx_adv[31:0] >= thresh_reg);
    assign st_set[ST_OVF_BIT]    = ovf;
    assign st_set[ST_FULL_BIT]   = start & ~room;           // [R13]
    wire [2:0] st_clr = wr_stat && wb_sel_i[0] ? wb_dat_i[2:0]
                                              : 3'h0;
    assign sticky_next = (sticky_reg & ~st_clr) | st_set;

    // Enable register: software write, then forced clears
    always_comb
    begin
        pse_next = wr_pse ? wmerge_pse : pse_reg;            // [R17]
        if (smm_entry | machine_check_i)
        begin
            pse_next[PSE_EN_BIT] = 1'b0;               // [R20] [R21]
        end
    end

    // Counter next value: write, reload on overflow, count
    assign count_next = wr_count ? merge(count_reg, wb_dat_i, wb_sel_i)
                      : ovf ? reload_reg                     // [R12]
                      : inc ? count_reg + 32'h1 : count_reg; // [R6]

    // Index: hardware advance wins over software write
    always_comb
    begin
        if (advance)
        begin
            index_next = idx_adv[31:0];                      // [R23]
        end
        else if (wr_index)
        begin
            index_next = merge(index_reg, wb_dat_i, wb_sel_i);
        end
        else
        begin
            index_next = index_reg;
        end
    end

    // Register read decode
    always_comb
    begin
        unique case (wb_adr_i)
            OFF_PSE:    reg_rdata = pse_reg;
            OFF_MATRIX: reg_rdata = matrix_reg;
            OFF_MISC:   reg_rdata = misc_reg;                // [R16]
            OFF_FEAT:   reg_rdata = FEAT_VAL;                // [R15]
            OFF_UPSEL:  reg_rdata = up_reg;
            OFF_DNSEL:  reg_rdata = dn_reg;
            OFF_FESEL:  reg_rdata = fe_reg;
            OFF_CFG:    reg_rdata = cfg_reg;
            OFF_COUNT:  reg_rdata = count_reg;
            OFF_BASE:   reg_rdata = base_reg;
            OFF_INDEX:  reg_rdata = index_reg;
            OFF_ABSMAX: reg_rdata = absmax_reg;
            OFF_THRESH: reg_rdata = thresh_reg;
            OFF_RELOAD: reg_rdata = reload_reg;
            OFF_STATUS: reg_rdata = {27'h0, smm_i, busy, sticky_reg};
            default:    reg_rdata = REG_RST;
        endcase
    end

    // Bus handshake: ack two cycles after the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= REG_RST;
        end
        else
        begin
            req_reg <= bus_req;
            ack_reg <= req_reg;
            if (req_reg && !wb_we_i)
            begin
                dat_reg <= in_mem ? mem_rdata : reg_rdata;
            end
        end
    end

    // Software-written configuration registers
    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            matrix_reg <= REG_RST;
            misc_reg   <= REG_RST;
            up_reg     <= REG_RST;
            dn_reg     <= REG_RST;
            fe_reg     <= REG_RST;
            cfg_reg    <= REG_RST;
            base_reg   <= REG_RST;
            absmax_reg <= REG_RST;
            thresh_reg <= REG_RST;
            reload_reg <= REG_RST;
        end
        else if (wr_en)
        begin
            unique case (wb_adr_i)
                OFF_MATRIX: matrix_reg <= merge(matrix_reg, wb_dat_i, wb_sel_i);
                OFF_MISC:   misc_reg   <= merge(misc_reg, wb_dat_i, wb_sel_i)
                                          & ~(32'h1 << ABSENT_BIT);
                OFF_UPSEL:  up_reg     <= merge(up_reg, wb_dat_i, wb_sel_i);
                OFF_DNSEL:  dn_reg     <= merge(dn_reg, wb_dat_i, wb_sel_i);
                OFF_FESEL:  fe_reg     <= merge(fe_reg, wb_dat_i, wb_sel_i);
                OFF_CFG:    cfg_reg    <= merge(cfg_reg, wb_dat_i, wb_sel_i);
                OFF_BASE:   base_reg   <= merge(base_reg, wb_dat_i, wb_sel_i);
                OFF_ABSMAX: absmax_reg <= merge(absmax_reg, wb_dat_i, wb_sel_i);
                OFF_THRESH: thresh_reg <= merge(thresh_reg, wb_dat_i, wb_sel_i);
                OFF_RELOAD: reload_reg <= merge(reload_reg, wb_dat_i, wb_sel_i);
                default:    ;
            endcase
        end
    end

    // Hardware-updated state
    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            pse_reg    <= REG_RST;
            count_reg  <= REG_RST;
            index_reg  <= REG_RST;
            sticky_reg <= 3'h0;
            smm_d_reg  <= 1'b0;
        end
        else
        begin
            pse_reg    <= pse_next;
            count_reg  <= count_next;
            index_reg  <= index_next;
            sticky_reg <= sticky_next;
            smm_d_reg  <= smm_i;
        end
    end

    // Record writer: snapshot on overflow, then one word a cycle
    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            state_reg <= ST_IDLE;
            word_reg  <= 4'h0;
            snap_reg  <= '0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    word_reg <= 4'h0;
                    if (start && room)
                    begin
                        snap_reg  <= arch_i;                 // [R12]
                        state_reg <= ST_WRITE;
                    end
                end
                ST_WRITE:
                begin
                    if (smm_i)
                    begin
                        word_reg <= word_reg;                // [R20]
                    end
                    else if (advance)
                    begin
                        state_reg <= ST_IDLE;                // [R23]
                    end
                    else
                    begin
                        word_reg <= word_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // Records buffer
    record_mem u_mem (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (wb_adr_i[9:2]),
        .rdata_o (mem_rdata)
    );

    // Outputs; one interrupt line for threshold and, with CFG_OVI_BIT set, overflow
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = sticky_reg[ST_THRESH_BIT]
                 | (sticky_reg[ST_OVF_BIT] & cfg_reg[CFG_OVI_BIT]); // [R19]
endmodule
`default_nettype wire

// *** hdl/sampling_pkg.sv ***
/*
 Package for the retirement tagging and precise sampling block:
 register offsets, field positions, reset values, carrier structs.
 Assumes a 12-bit Wishbone byte address and a 32-bit data bus.
*/
`default_nettype none
package sampling_pkg;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFF_PSE    = 12'h000;
    localparam logic [11:0] OFF_MATRIX = 12'h004;
    localparam logic [11:0] OFF_MISC   = 12'h008;
    localparam logic [11:0] OFF_FEAT   = 12'h00c;
    localparam logic [11:0] OFF_UPSEL  = 12'h010;
    localparam logic [11:0] OFF_DNSEL  = 12'h014;
    localparam logic [11:0] OFF_FESEL  = 12'h018;
    localparam logic [11:0] OFF_CFG    = 12'h01c;
    localparam logic [11:0] OFF_COUNT  = 12'h020;
    localparam logic [11:0] OFF_BASE   = 12'h024;
    localparam logic [11:0] OFF_INDEX  = 12'h028;
    localparam logic [11:0] OFF_ABSMAX = 12'h02c;
    localparam logic [11:0] OFF_THRESH = 12'h030;
    localparam logic [11:0] OFF_RELOAD = 12'h034;
    localparam logic [11:0] OFF_STATUS = 12'h038;
    // Record memory window: address bits 11:10 equal 01
    localparam logic [1:0]  MEM_WINDOW = 2'h1;
    // Field positions
    localparam int PSE_EN_BIT    = 24;
    localparam int PSE_AUX_BIT   = 25;
    localparam int TAG_EN_BIT    = 4;
    localparam int TAG_VAL_LSB   = 5;
    localparam int CP_MASK_LSB   = 9;
    localparam int WP_MASK_LSB   = 13;
    localparam int DN_EVT_LSB    = 24;
    localparam int ABSENT_BIT    = 12;
    localparam int FEAT_DS_BIT   = 21;
    localparam int CFG_EN_BIT    = 0;
    localparam int CFG_OVI_BIT   = 1;
    localparam int ST_THRESH_BIT = 0;
    localparam int ST_OVF_BIT    = 1;
    localparam int ST_FULL_BIT   = 2;
    // Downstream event select codes
    localparam logic [2:0] EVT_NONE    = 3'h0;
    localparam logic [2:0] EVT_FRONT   = 3'h1;
    localparam logic [2:0] EVT_EXEC    = 3'h2;
    localparam logic [2:0] EVT_REPLAY  = 3'h3;
    localparam logic [2:0] EVT_RETIRED = 3'h4;
    // Reset values and record size
    localparam logic [31:0] REG_RST      = 32'h0000_0000;
    localparam logic [31:0] FEAT_VAL     = 32'h0020_0000;
    localparam logic [3:0]  RECORD_WORDS = 4'ha;
    localparam logic [3:0]  LAST_WORD    = 4'h9;

    typedef enum logic {ST_IDLE, ST_WRITE} wr_state_e;

    // One retiring micro-op with its event hits
    typedef struct packed {
        logic       valid;
        logic       correct_path;
        logic       io;
        logic       uncached;
        logic       locked;
        logic       is_return;
        logic       far_xfer;
        logic [3:0] fe_hits;
        logic [3:0] exec_hits;
        logic [3:0] replay_hits;
    } uop_s;

    // Architectural state copied into a record
    typedef struct packed {
        logic [7:0][31:0] gpr;
        logic [31:0]      flags;
        logic [31:0]      ip;
    } arch_state_s;
endpackage
`default_nettype wire

// *** sim/sampling_core_asserts.sv ***
/*
 Checker for sampling_core: handshake, fixed reads, resets.
 Assumes binding to sampling_core, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sampling_core_asserts (
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [11:0]               wb_adr_i,
    input wire logic [31:0]               wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire logic                      init_i,
    input wire logic                      irq_o
);
    import sampling_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Read answers and the unmapped register hole
    wire logic rd_ack   = wb_ack_o && !wb_we_i;
    wire logic reg_hole = (wb_adr_i[11:10] == 2'h0)
                       && (wb_adr_i > OFF_STATUS);

    // Handshake shape
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_latency: assert property
        ($rose(wb_cyc_i && wb_stb_i) |=> !wb_ack_o ##1 wb_ack_o)
        else $error("ack not in cycle two of the request");
    a_dat_hold: assert property ($changed(wb_dat_o) |-> rd_ack)
        else $error("read data moved outside a read answer");
    // Fixed read values
    a_feat_value: assert property
        (rd_ack && wb_adr_i == OFF_FEAT |-> wb_dat_o == FEAT_VAL)
        else $error("feature word wrong");
    a_absent_clear: assert property
        (rd_ack && wb_adr_i == OFF_MISC |-> !wb_dat_o[ABSENT_BIT])
        else $error("absent flag read set");
    a_hole_zero: assert property (rd_ack && reg_hole |-> wb_dat_o == '0)
        else $error("unmapped offset read nonzero");
    // Reset and init
    a_reset_quiet: assert property
        (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && wb_dat_o == '0)
        else $error("outputs not cleared by reset");
    a_init_irq: assert property (init_i |=> !irq_o)
        else $error("interrupt survived init");

    // Main scenarios
    c_feat_read: cover property (rd_ack && wb_adr_i == OFF_FEAT);
    c_irq_rise: cover property ($rose(irq_o));
    c_init_seen: cover property (init_i);
endmodule
bind sampling_core sampling_core_asserts chk_u (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .wb_cyc_i        (wb_cyc_i),
    .wb_stb_i        (wb_stb_i),
    .wb_we_i         (wb_we_i),
    .wb_adr_i        (wb_adr_i),
    .wb_dat_o        (wb_dat_o),
    .wb_ack_o        (wb_ack_o),
    .init_i          (init_i),
    .irq_o           (irq_o)
);
`default_nettype wire

// *** sim/tb_top.sv ***
/*
 Bench for sampling_core: registers, tags, records, modes.
 Assumes a 25 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sampling_pkg::*;
    typedef struct packed {
        logic        we;
        logic [11:0] adr;
        logic [31:0] wd;
        logic [3:0]  sel;
        logic [31:0] mask;
        logic [31:0] exp;
    } row_s;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic [3:0]  wb_sel_i = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    uop_s        retire_i = '0;
    arch_state_s arch_i = '0;
    logic        smm_i = 1'b0;
    logic        machine_check_i = 1'b0;
    logic        init_i = 1'b0;
    logic        irq_o;
    logic [31:0] rdat;
    int          miscompares = 0;
    int          compares = 0;
    row_s        rows [7] = '{
        '{1'b0, OFF_FEAT,   32'h0, 4'hf, 32'hffff_ffff, FEAT_VAL},
        '{1'b1, OFF_FEAT,   32'hffff_ffff, 4'hf, 32'hffff_ffff, FEAT_VAL},
        '{1'b1, OFF_MISC,   32'hffff_ffff, 4'hf, 32'h0000_1000, 32'h0},
        '{1'b1, OFF_PSE,    32'h0300_000f, 4'hf, 32'h0300_000f,
          32'h0300_000f},
        '{1'b1, 12'h03c,    32'hffff_ffff, 4'hf, 32'hffff_ffff, 32'h0},
        '{1'b1, OFF_RELOAD, 32'haabb_ccdd, 4'h1, 32'hffff_ffff, 32'hdd},
        '{1'b1, OFF_COUNT,  32'h1234_5678, 4'hf, 32'hffff_ffff,
          32'h1234_5678}};

    // Free-running clock
    always #12.5 clk_i = ~clk_i;

    sampling_core dut_u (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .wb_cyc_i        (wb_cyc_i),
        .wb_stb_i        (wb_stb_i),
        .wb_we_i         (wb_we_i),
        .wb_adr_i        (wb_adr_i),
        .wb_dat_i        (wb_dat_i),
        .wb_sel_i        (wb_sel_i),
        .wb_dat_o        (wb_dat_o),
        .wb_ack_o        (wb_ack_o),
        .retire_i        (retire_i),
        .arch_i          (arch_i),
        .smm_i           (smm_i),
        .machine_check_i (machine_check_i),
        .init_i          (init_i),
        .irq_o           (irq_o)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One classic bus cycle, bounded wait for ack
    task automatic xfer(input logic we, input logic [11:0] adr,
                        input logic [31:0] wd, input logic [3:0] sel,
                        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= sel;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        check({31'h0, wb_ack_o}, 32'h1, "bus ack");
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, adr, wd, 4'hf, d);
    endtask

    task automatic rd_chk(input logic [11:0] adr, input logic [31:0] mask,
                          input logic [31:0] exp, input string msg);
        logic [31:0] d;
        xfer(1'b0, adr, 32'h0, 4'hf, d);
        check(d & mask, exp, msg);
    endtask

    // Retire one micro-op for n back-to-back cycles
    task automatic send(input uop_s u, input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            retire_i <= u;
        end
        @(posedge clk_i);
        retire_i <= '0;
    endtask

    function automatic uop_s uop(input logic cp, input logic [4:0] excl,
                                 input logic [3:0] fe, input logic [3:0] ex,
                                 input logic [3:0] rp);
        return {1'b1, cp, excl, fe, ex, rp};
    endfunction

    function automatic logic [31:0] word_exp(input int k);
        if (k < 8)
            return 32'h1000_0000 + 32'(k);
        return (k == 8) ? 32'h0000_0202 : 32'h0040_1000;
    endfunction

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        end_of_test();
    end

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 8; k++)
            arch_i.gpr[k] <= word_exp(k);
        arch_i.flags <= word_exp(8);
        arch_i.ip <= word_exp(9);
        // Register table rows
        foreach (rows[i])
        begin
            if (rows[i].we)
                xfer(1'b1, rows[i].adr, rows[i].wd, rows[i].sel, rdat);
            rd_chk(rows[i].adr,rows[i].mask,rows[i].exp,"row");
        end
        // Exec tags, junk downstream tag fields
        wr(OFF_PSE, 32'h0);
        wr(OFF_CFG, 32'h1);
        wr(OFF_COUNT, 32'h0);
        wr(OFF_UPSEL, 32'h0000_0071);
        wr(OFF_DNSEL, 32'h0200_03f0);
        send(uop(1'b1, 5'h0, 4'h0, 4'h1, 4'h0), 2);
        for (int k = 0; k < 5; k++)
            send(uop(1'b1, 5'h1 << k, 4'h0, 4'h1, 4'h0), 1);
        send(uop(1'b1, 5'h0, 4'hf, 4'h2, 4'hf), 1);
        rd_chk(OFF_COUNT, '1, 32'h2, "exec");
        wr(OFF_UPSEL, 32'h0000_0091);
        send(uop(1'b1, 5'h0, 4'h0, 4'h1, 4'h0), 1);
        rd_chk(OFF_COUNT, '1, 32'h2, "unmatched tag");
        // Front-end needs a path mask bit
        wr(OFF_FESEL, 32'hf);
        wr(OFF_COUNT, 32'h0);
        wr(OFF_DNSEL, 32'h0100_0000);
        send(uop(1'b1, 5'h0, 4'h1, 4'h0, 4'h0), 1);
        rd_chk(OFF_COUNT, '1, 32'h0, "front no mask");
        wr(OFF_DNSEL, 32'h0100_0200);
        send(uop(1'b1, 5'h0, 4'h1, 4'h0, 4'h0), 1);
        rd_chk(OFF_COUNT, '1, 32'h1, "front masked");
        // Replay tagging, non-precise then aux-only
        wr(OFF_MATRIX, 32'hf);
        wr(OFF_PSE, 32'hf);
        wr(OFF_DNSEL, 32'h0300_0200);
        send(uop(1'b1, 5'h0, 4'h0, 4'h0, 4'h1), 1);
        rd_chk(OFF_COUNT, '1, 32'h2, "replay count");
        wr(OFF_PSE, 32'h0200_000f);
        send(uop(1'b1, 5'h0, 4'h0, 4'h0, 4'h1), 1);
        rd_chk(OFF_COUNT, '1, 32'h2, "replay aux");
        // Precise records: two fit, the third is refused
        wr(OFF_INDEX, 32'h0);
        wr(OFF_ABSMAX, 32'd20);
        wr(OFF_THRESH, 32'd10);
        wr(OFF_RELOAD, 32'hffff_fffe);
        wr(OFF_COUNT, 32'hffff_ffff);
        wr(OFF_UPSEL, 32'h0000_0071);
        wr(OFF_DNSEL, 32'h0200_0200);
        wr(OFF_PSE, 32'h0100_0000);
        send(uop(1'b1, 5'h0, 4'h0, 4'h1, 4'h0), 1);
        repeat (12) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1, "threshold irq");
        rd_chk(OFF_INDEX, '1, 32'd10, "index step");
        rd_chk(OFF_COUNT, '1, 32'hffff_fffe, "reload");
        for (int k = 0; k < 10; k++)
            rd_chk(12'h400 + 12'(4 * k), '1, word_exp(k), "record");
        send(uop(1'b1, 5'h0, 4'h0, 4'h1, 4'h0), 2);
        repeat (12) @(posedge clk_i);
        send(uop(1'b1, 5'h0, 4'h0, 4'h1, 4'h0), 2);
        repeat (12) @(posedge clk_i);
        rd_chk(OFF_INDEX, '1, 32'd20, "no wrap index");
        rd_chk(12'h400, '1, word_exp(0), "no wrap data");
        rd_chk(OFF_STATUS, 32'h4, 32'h4, "full flag");
        xfer(1'b1, OFF_STATUS, 32'h7, 4'h1, rdat);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0, "irq cleared");
        // Management mode, machine check, init
        wr(OFF_PSE, 32'h0100_0000);
        wr(OFF_COUNT, 32'h0);
        @(posedge clk_i);
        smm_i <= 1'b1;
        send(uop(1'b1, 5'h0, 4'h0, 4'h1, 4'h0), 1);
        smm_i <= 1'b0;
        rd_chk(OFF_PSE, 32'h0100_0000, 32'h0, "smm exit");
        rd_chk(OFF_COUNT, '1, 32'h0, "smm paused");
        wr(OFF_PSE, 32'h0100_0000);
        @(posedge clk_i);
        machine_check_i <= 1'b1;
        @(posedge clk_i);
        machine_check_i <= 1'b0;
        rd_chk(OFF_PSE, 32'h0100_0000, 32'h0, "mc exit");
        wr(OFF_COUNT, 32'h5);
        @(posedge clk_i);
        init_i <= 1'b1;
        @(posedge clk_i);
        init_i <= 1'b0;
        rd_chk(OFF_COUNT, '1, 32'h0, "init count");
        rd_chk(OFF_CFG, '1, 32'h0, "init cfg");
        end_of_test();
    end
endmodule
`default_nettype wire
